/* File: ticc_pkg.sv */
// constants and helpers shared by the timer input capture core
// ****************************************************************
// Overview of operation
// R1: pins 0-2 are capture inputs or GPIO
// R2: pins 4-6 are compare outputs or GPIO
// R3: pin 3: GPIO, capture 4, compare 5, compare 1
// R4: compare 1 may drive any of pins 3-7
// R5: pin 7: GPIO, accumulator input, compare 1 output
// R6: port read: pin level in, driver level out
// R7: port writes to timer pins latch only
// R8: count writable only in special mode
// R9: overflow flag on wrap, write one clears
// R10: overflow flag with enable requests interrupt
// R11: prescale codes divide by 1, 4, 8, 16
// R12: prescale written once, first 64 cycles only; special mode writes it any time
// R13: pin 3 direction bit: 0 in, 1 out
// R14: pin 3 select: 0 compare 5, 1 capture 4
// R15: shared register write forces capture when output
// R16: selected edge latches counter into capture register
// R17: capture latched while counter value stands stable
// R18: both capture bytes loaded in one transfer
// R19: capture read blocks new transfer one cycle
// R20: capture during block is delayed, never lost
// R21: shared register holds capture 4 value
// R22: counter starts at zero, wraps, keeps counting
// R23: edge codes: off, rise, fall, any; reset off
// R24: capture flag set on edge, write one clears
// R25: capture flag with enable requests interrupt
// R26: software reads capture word in one access
// ****************************************************************
package ticc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_DATA = 8'h00;
  localparam logic [7:0] IDX_PORT_DIR  = 8'h01;
  localparam logic [7:0] IDX_COUNT     = 8'h0E;
  localparam logic [7:0] IDX_CAP1      = 8'h10;
  localparam logic [7:0] IDX_CAP2      = 8'h12;
  localparam logic [7:0] IDX_CAP3      = 8'h14;
  localparam logic [7:0] IDX_SHARED    = 8'h1E;
  localparam logic [7:0] IDX_EDGE      = 8'h21;
  localparam logic [7:0] IDX_CAP_MASK  = 8'h22;
  localparam logic [7:0] IDX_CAP_FLAGS = 8'h23;
  localparam logic [7:0] IDX_OVF_MASK  = 8'h24;
  localparam logic [7:0] IDX_OVF_FLAGS = 8'h25;
  localparam logic [7:0] IDX_ACC_CTL   = 8'h26;
  // field positions
  localparam int OVF_FLAG_BIT  = 7;
  localparam int OVF_EN_BIT    = 7;
  localparam int PIN3          = 3;
  localparam int PIN3_FUNC_BIT = 2;
  localparam int ACC_PIN       = 7;
  localparam logic [2:0] CAP_PIN  [4] = '{3'd2, 3'd1, 3'd0, 3'd3};
  localparam int         EDGE_LSB [4] = '{4, 2, 0, 6};
  // reset values and counts
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_COUNT  = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] RST_C5     = 16'hFFFF;
  localparam logic [6:0]  PS_WINDOW  = 7'd64;
  // edge select codes
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_ANY  = 2'b11;

  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction : byte_addr

  // terminal value of the prescale divider for each code
  function automatic logic [3:0] ps_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   ps_limit = 4'h0;
      2'b01:   ps_limit = 4'h3;
      2'b10:   ps_limit = 4'h7;
      default: ps_limit = 4'hF;
    endcase
  endfunction : ps_limit

  function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
    case (sel)
      EDGE_RISE: edge_hit = ~prv & cur;
      EDGE_FALL: edge_hit = prv & ~cur;
      EDGE_ANY:  edge_hit = prv ^ cur;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit
endpackage : ticc_pkg

/* File: ticc_capture_mem.sv */
// capture value store with registered read port
`timescale 1ns/1ps
module ticc_capture_mem #(
  parameter int WORDS = 4,
  parameter int W     = 16
) (
  input  wire logic                     clk,
  input  wire logic [WORDS-1:0]         we,
  input  wire logic [WORDS*W-1:0]       wdata,
  input  wire logic [$clog2(WORDS)-1:0] raddr,
  output logic      [W-1:0]             rdata
);
  logic [W-1:0] mem [WORDS];

  if (WORDS < 2 || W < 1)
  begin : g_chk
    $error("ticc_capture_mem needs at least two words");
  end

  // every word may load in the same cycle; contents survive reset
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < WORDS; i++)
    begin
      if (we[i])
      begin
        mem[i] <= wdata[i*W +: W];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule : ticc_capture_mem

/* File: ticc_core.sv */
// timer counter, input capture and port pin control with AHB-Lite slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ticc_core #(
  parameter int COUNT_W = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        special_mode,
  input  wire logic [7:0]  port_in,
  output logic      [7:0]  port_out,
  output logic      [7:0]  port_oe_n,
  input  wire logic [3:0]  compare_enable,
  input  wire logic [3:0]  compare_level,
  input  wire logic [4:0]  compare_one_mask,
  input  wire logic [4:0]  compare_one_level,
  output logic      [15:0] compare_five_value,
  output logic             pin3_capture_mode,
  output logic             accumulator_input,
  output logic      [15:0] free_running_count,
  output logic             main_timer_tick,
  output logic             overflow_irq,
  output logic             capture_irq
);
  import ticc_pkg::*;

  if (COUNT_W != 16)
  begin : g_chk
    $error("ticc_core supports a 16-bit counter only");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  port_latch_reg, port_dir_reg, edge_reg, acc_ctl_reg;
  logic [3:0]  cap_mask_reg, cap_flag_reg, blk_reg, pend_reg;
  logic        ovf_flag_reg, ovf_en_reg, ps_done_reg;
  logic [1:0]  ps_reg;
  logic [6:0]  win_reg;
  logic [3:0]  div_reg;
  logic [15:0] count_reg, c5_reg;
  logic [15:0] pend_val_reg [4];
  logic [7:0]  sync1_reg, sync2_reg, prev_reg;
  logic        wr_pend_reg, mem_sel_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rdata_reg;
  logic [15:0] mem_rdata;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire         acc_xfer = hsel & htrans[1] & hready;
  wire         rd_acc   = acc_xfer & ~hwrite;
  wire         wr_acc   = acc_xfer & hwrite;
  wire [7:0]   ra       = haddr[7:0];
  wire         r_cap1   = ra == byte_addr(IDX_CAP1);
  wire         r_cap2   = ra == byte_addr(IDX_CAP2);
  wire         r_cap3   = ra == byte_addr(IDX_CAP3);
  wire         r_shr    = ra == byte_addr(IDX_SHARED);
  wire [3:0]   r_cap    = {r_shr, r_cap3, r_cap2, r_cap1};
  wire [1:0]   mem_raddr = r_cap1 ? 2'd0 : r_cap2 ? 2'd1 : r_cap3 ? 2'd2 : 2'd3;

  wire         w_port   = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_PORT_DATA));
  wire         w_dir    = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_PORT_DIR));
  wire         w_cnt    = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_COUNT));
  wire         w_shr    = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_SHARED));
  wire         w_edge   = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_EDGE));
  wire         w_cmask  = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_CAP_MASK));
  wire         w_cflag  = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_CAP_FLAGS));
  wire         w_omask  = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_OVF_MASK));
  wire         w_oflag  = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_OVF_FLAGS));
  wire         w_acc    = wr_pend_reg & (wr_addr_reg == byte_addr(IDX_ACC_CTL));

  // ****************************************************************
  // pin 3 selection and port pins
  // ****************************************************************
  wire       pin3_dir = port_dir_reg[PIN3];           // [R13]
  wire       cap4_sel = acc_ctl_reg[PIN3_FUNC_BIT];   // [R14]
  // timer ownership: compare 2-4 on pins 4-6, compare 5 on pin 3
  wire [7:0] oc_own   = {1'b0, compare_enable[2:0], compare_enable[3] & ~cap4_sel, 3'b000};
  wire [7:0] c1_own   = {compare_one_mask, 3'b000};   // [R4]
  wire [7:0] c1_lvl   = {compare_one_level, 3'b000};
  wire [7:0] oc_lvl   = {1'b0, compare_level[2:0], compare_level[3], 3'b000};
  wire [7:0] own      = oc_own | c1_own;              // [R2] [R3] [R5]
  // compare 1 wins where both claim a pin; latch never reaches owned pins
  wire [7:0] drv_lvl  = (c1_own & c1_lvl) | (~c1_own & oc_own & oc_lvl)
                      | (~own & port_latch_reg);      // [R7]
  wire [7:0] drives   = own | port_dir_reg;           // [R1]
  wire [7:0] port_rd  = (drives & drv_lvl) | (~drives & sync2_reg);  // [R6]

  assign port_out          = drv_lvl;
  assign port_oe_n         = ~drives;
  assign pin3_capture_mode = cap4_sel;
  assign accumulator_input = sync2_reg[ACC_PIN];      // [R5]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= RST_BYTE;
      sync2_reg <= RST_BYTE;
      prev_reg  <= RST_BYTE;
    end
    else
    begin
      sync1_reg <= port_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ****************************************************************
  // prescaler and free-running counter
  // ****************************************************************
  wire tick     = div_reg >= ps_limit(ps_reg);        // [R11]
  wire wrap     = tick & (count_reg == COUNT_MAX);
  wire win_open = win_reg < PS_WINDOW;
  wire ps_wr    = w_omask & (special_mode | (win_open & ~ps_done_reg));  // [R12]

  assign main_timer_tick    = tick;
  assign free_running_count = count_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_reg   <= 4'h0;
      count_reg <= RST_COUNT;
      win_reg   <= 7'd0;
    end
    else
    begin
      div_reg   <= tick ? 4'h0 : div_reg + 4'h1;
      win_reg   <= win_open ? win_reg + 7'd1 : win_reg;
      if (w_cnt && special_mode)
        count_reg <= hwdata[15:0];                    // [R8]
      else if (tick)
        count_reg <= count_reg + 16'h0001;            // [R22]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ps_reg      <= 2'b00;
      ps_done_reg <= 1'b0;
      ovf_en_reg  <= 1'b0;
      ovf_flag_reg <= 1'b0;
    end
    else
    begin
      if (ps_wr)
      begin
        ps_reg      <= hwdata[1:0];
        ps_done_reg <= 1'b1;
      end
      if (w_omask)
        ovf_en_reg <= hwdata[OVF_EN_BIT];
      // wrap wins over a clear in the same cycle
      ovf_flag_reg <= wrap | (ovf_flag_reg & ~(w_oflag & hwdata[OVF_FLAG_BIT]));  // [R9]
    end
  end

  assign overflow_irq = ovf_flag_reg & ovf_en_reg;    // [R10]

  // ****************************************************************
  // capture channels
  // ****************************************************************
  logic [3:0]  req, mem_we;
  logic [63:0] mem_wdata;
  wire  force4 = w_shr & pin3_dir & cap4_sel;         // [R15]
  wire  bus_w4 = w_shr & ~cap4_sel;

  for (genvar i = 0; i < 4; i++)
  begin : g_ch
    wire ok = (i != 3) | cap4_sel;
    wire hit = ok & edge_hit(edge_reg[EDGE_LSB[i] +: 2],
                             prev_reg[CAP_PIN[i]], sync2_reg[CAP_PIN[i]]);  // [R16] [R23]
    assign req[i] = hit | ((i == 3) & force4);
    // transfer from the stable counter word; delayed one cycle if blocked
    assign mem_we[i] = (~blk_reg[i] & (req[i] | pend_reg[i])) | ((i == 3) & bus_w4);  // [R17]
    assign mem_wdata[i*16 +: 16] = ((i == 3) & bus_w4) ? hwdata[15:0] :
                                   req[i] ? count_reg : pend_val_reg[i];  // [R18] [R20]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blk_reg  <= 4'h0;
      pend_reg <= 4'h0;
      for (int i = 0; i < 4; i++)
        pend_val_reg[i] <= RST_COUNT;
    end
    else
    begin
      blk_reg  <= rd_acc ? r_cap : 4'h0;              // [R19]
      pend_reg <= (pend_reg | req) & blk_reg;         // [R20]
      for (int i = 0; i < 4; i++)
        if (req[i])
          pend_val_reg[i] <= count_reg;
    end
  end

  ticc_capture_mem #(
    .WORDS (4),
    .W     (16)
  ) u_mem (
    .clk   (hclk),
    .we    (mem_we),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)                                // [R21]
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap_flag_reg <= 4'h0;
    else
      cap_flag_reg <= req | (cap_flag_reg & ~({4{w_cflag}} & hwdata[3:0]));  // [R24]
  end

  assign capture_irq = |(cap_flag_reg & cap_mask_reg);  // [R25]

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_latch_reg <= RST_BYTE;
      port_dir_reg   <= RST_BYTE;
      edge_reg       <= RST_BYTE;
      acc_ctl_reg    <= RST_BYTE;
      cap_mask_reg   <= 4'h0;
      c5_reg         <= RST_C5;
    end
    else
    begin
      if (w_port)
        port_latch_reg <= hwdata[7:0];                // [R7]
      if (w_dir)
        port_dir_reg <= hwdata[7:0];
      if (w_edge)
        edge_reg <= hwdata[7:0];
      if (w_acc)
        acc_ctl_reg <= hwdata[7:0];
      if (w_cmask)
        cap_mask_reg <= hwdata[3:0];
      if (bus_w4)
        c5_reg <= hwdata[15:0];
    end
  end

  assign compare_five_value = c5_reg;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  wire [31:0] rd_word =
      (ra == byte_addr(IDX_PORT_DATA)) ? {24'h0, port_rd} :
      (ra == byte_addr(IDX_PORT_DIR))  ? {24'h0, port_dir_reg} :
      (ra == byte_addr(IDX_COUNT))     ? {16'h0, count_reg} :
      (ra == byte_addr(IDX_EDGE))      ? {24'h0, edge_reg} :
      (ra == byte_addr(IDX_CAP_MASK))  ? {28'h0, cap_mask_reg} :
      (ra == byte_addr(IDX_CAP_FLAGS)) ? {28'h0, cap_flag_reg} :
      (ra == byte_addr(IDX_OVF_MASK))  ? {24'h0, ovf_en_reg, 5'h00, ps_reg} :
      (ra == byte_addr(IDX_OVF_FLAGS)) ? {24'h0, ovf_flag_reg, 7'h00} :
      (ra == byte_addr(IDX_ACC_CTL))   ? {24'h0, acc_ctl_reg} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      mem_sel_reg <= 1'b0;
      rdata_reg   <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= wr_acc;
      wr_addr_reg <= ra;
      mem_sel_reg <= rd_acc & (|r_cap);
      rdata_reg   <= rd_acc ? rd_word : 32'h0;
    end
  end

  // whole word read in one access keeps both bytes coherent [R26]
  assign hrdata    = mem_sel_reg ? {16'h0, mem_rdata} : rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_ovf_set;
    wrap && !(w_cnt && special_mode) |=> ovf_flag_reg && count_reg == RST_COUNT;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap"); // [R9]

  property p_ovf_irq;
    wrap && ovf_en_reg && !w_omask |=> overflow_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing"); // [R10]

  property p_ovf_quiet;
    !ovf_en_reg |-> !overflow_irq;
  endproperty
  a_ovf_quiet: assert property (p_ovf_quiet) else $error("irq while disabled"); // [R10]

  property p_div4;
    ps_reg == 2'b01 && tick && !special_mode |=> !tick [*3] ##1 tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four spacing wrong"); // [R11]

  property p_ps_lock;
    ps_done_reg && !special_mode |=> $stable(ps_reg);
  endproperty
  a_ps_lock: assert property (p_ps_lock) else $error("prescale changed after lock"); // [R12]

  property p_cnt_ro;
    w_cnt && !special_mode |=> count_reg - $past(count_reg) == {15'h0000, $past(tick)};
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count written in normal mode"); // [R8]

  property p_cap_now;
    req[0] && !blk_reg[0] |-> mem_we[0] && mem_wdata[15:0] == count_reg;
  endproperty
  a_cap_now: assert property (p_cap_now) else $error("capture not transferred"); // [R16] [R18]

  property p_cap_block;
    blk_reg[1] |-> !mem_we[1];
  endproperty
  a_cap_block: assert property (p_cap_block) else $error("transfer during read block"); // [R19]

  property p_cap_kept;
    req[2] && blk_reg[2] |-> ##[1:2] mem_we[2];
  endproperty
  a_cap_kept: assert property (p_cap_kept) else $error("blocked capture lost"); // [R20]

  property p_force;
    w_shr && pin3_dir && cap4_sel |=> cap_flag_reg[3];
  endproperty
  a_force: assert property (p_force) else $error("forced capture missing"); // [R15]

  property p_flag;
    req[0] |=> cap_flag_reg[0];
  endproperty
  a_flag: assert property (p_flag) else $error("capture flag not set"); // [R24]
endmodule : ticc_core

/* File: ticc_pin_model.sv */
// partner model: outside event sources on the port A timer pins
`timescale 1ns/1ps
module ticc_pin_model (
  input  wire logic       hclk,
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe_n,
  output logic      [7:0] port_in
);
  logic [7:0] ext_level;

  initial ext_level = 8'h00;

  // ****************************************************************
  // pin level
  // ****************************************************************
  // device driver wins where enabled, else the outside source
  assign port_in = (port_oe_n & ext_level) | (~port_oe_n & port_out);

  // new event levels launched just after a clock edge
  task automatic drive(input logic [7:0] lvl);
    @(posedge hclk);
    ext_level <= lvl;
  endtask : drive
endmodule : ticc_pin_model

/* File: ticc_core_bench.sv */
// self-checking testbench for the timer input capture core
`timescale 1ns/1ps
module ticc_core_bench;
  import ticc_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        special_mode;
  logic [7:0]  port_in;
  logic [7:0]  port_out;
  logic [7:0]  port_oe_n;
  logic [3:0]  compare_enable;
  logic [3:0]  compare_level;
  logic [4:0]  compare_one_mask;
  logic [4:0]  compare_one_level;
  logic [15:0] compare_five_value;
  logic        pin3_capture_mode;
  logic        accumulator_input;
  logic [15:0] free_running_count;
  logic        main_timer_tick;
  logic        overflow_irq;
  logic        capture_irq;
  int          n_mismatch;
  int          num_checks;
  logic [31:0] rd;
  logic [15:0] c0;

  assign hready = hreadyout;

  ticc_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .special_mode(special_mode),
    .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n),
    .compare_enable(compare_enable), .compare_level(compare_level),
    .compare_one_mask(compare_one_mask), .compare_one_level(compare_one_level),
    .compare_five_value(compare_five_value), .pin3_capture_mode(pin3_capture_mode),
    .accumulator_input(accumulator_input), .free_running_count(free_running_count),
    .main_timer_tick(main_timer_tick), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq));

  ticc_pin_model pm_u (.hclk(hclk), .port_out(port_out), .port_oe_n(port_oe_n),
    .port_in(port_in));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, byte_addr(idx)};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // captured word lies a few counts after the pin change
  task automatic cap_chk(input logic [7:0] idx);
    logic [15:0] d16;
    bus(1'b0, idx, 32'h0);
    d16 = rd[15:0] - c0;
    chk({31'h0, (rd[31:16] === 16'h0) && (d16 >= 16'h1) && (d16 <= 16'h8)}, 32'h1);
  endtask : cap_chk

  // cycles between two counter ticks
  task automatic gap_chk(input int exp);
    int n;
    n = 0;
    do @(posedge hclk); while (main_timer_tick !== 1'b1);
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (main_timer_tick !== 1'b1 && n < 40);
    chk(n, exp);
  endtask : gap_chk

  // ****************************************************************
  // clock and watchdog
  // ****************************************************************
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; special_mode = 1'b0; compare_enable = 4'h0;
    compare_level = 4'h0; compare_one_mask = 5'h00; compare_one_level = 5'h00;
    n_mismatch = 0; num_checks = 0; c0 = 16'h0000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, free_running_count < 16'h0003}, 32'h1);
    chk({port_oe_n, compare_five_value, 7'h00, hresp}, {8'hFF, 16'hFFFF, 8'h00});
    wr(IDX_OVF_MASK, 32'h01);
    gap_chk(4);
    wr(IDX_OVF_MASK, 32'h03);
    gap_chk(4);
    special_mode <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_OVF_MASK, k);
      gap_chk((k == 0) ? 1 : (2 << k));
    end
    wr(IDX_OVF_MASK, 32'h00);
    wr(IDX_COUNT, 32'hFFF8);
    repeat (20) @(posedge hclk);
    chk(overflow_irq, 32'h0);
    rdc(IDX_OVF_FLAGS, 32'h80);
    wr(IDX_OVF_MASK, 32'h80);
    @(posedge hclk);
    chk(overflow_irq, 32'h1);
    wr(IDX_OVF_FLAGS, 32'h80);
    @(posedge hclk);
    chk(overflow_irq, 32'h0);
    rdc(IDX_OVF_FLAGS, 32'h00);
    wr(IDX_COUNT, 32'hFFF0);
    repeat (20) @(posedge hclk);
    chk(overflow_irq, 32'h1);
    wr(IDX_COUNT, 32'h8000);
    bus(1'b0, IDX_COUNT, 32'h0);
    chk(rd & 32'hFFFFFFF0, 32'h8000);
    special_mode <= 1'b0;
    wr(IDX_COUNT, 32'h0000);
    chk(free_running_count[15], 32'h1);
    wr(IDX_EDGE, 32'h1B);
    wr(IDX_CAP_MASK, 32'h02);
    pm_u.drive(8'h07);
    c0 = free_running_count;
    repeat (8) @(posedge hclk);
    chk(capture_irq, 32'h0);
    rdc(IDX_CAP_FLAGS, 32'h05);
    cap_chk(IDX_CAP1);
    cap_chk(IDX_CAP3);
    wr(IDX_CAP_FLAGS, 32'h05);
    pm_u.drive(8'h00);
    c0 = free_running_count;
    repeat (8) @(posedge hclk);
    chk(capture_irq, 32'h1);
    rdc(IDX_CAP_FLAGS, 32'h06);
    cap_chk(IDX_CAP2);
    cap_chk(IDX_CAP3);
    wr(IDX_CAP_FLAGS, 32'h02);
    @(posedge hclk);
    chk(capture_irq, 32'h0);
    // edge lands in the data phase of the next capture read
    bus(1'b0, IDX_CAP3, 32'h0);
    pm_u.drive(8'h01);
    c0 = free_running_count;
    rdc(IDX_CAP3, rd);
    cap_chk(IDX_CAP3);
    wr(IDX_EDGE, 32'hC0);
    wr(IDX_ACC_CTL, 32'h04);
    @(posedge hclk);
    chk(pin3_capture_mode, 32'h1);
    wr(IDX_CAP_FLAGS, 32'h0F);
    wr(IDX_SHARED, 32'h1);
    rdc(IDX_CAP_FLAGS, 32'h00);
    wr(IDX_PORT_DIR, 32'h08);
    @(posedge hclk);
    chk(port_oe_n[3], 32'h0);
    c0 = free_running_count;
    wr(IDX_SHARED, 32'h1);
    rdc(IDX_CAP_FLAGS, 32'h08);
    cap_chk(IDX_SHARED);
    wr(IDX_PORT_DATA, 32'hFF);
    compare_one_mask <= 5'h10;
    compare_enable   <= 4'h1;
    pm_u.drive(8'hA5);
    @(posedge hclk);
    chk({port_out[7], port_oe_n[7]}, 32'h0);
    chk({port_out[4], port_oe_n[4]}, 32'h0);
    rdc(IDX_PORT_DATA, 32'h2D);
    compare_one_mask <= 5'h00;
    repeat (4) @(posedge hclk);
    chk(accumulator_input, 32'h1);
    test_done();
  end
endmodule : ticc_core_bench
